// ---- twc_client.sv ----
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module twc_client (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [twc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic global_irq_enable,
  output logic byte_irq,
  output logic addr_stop_irq
);
  import twc_pkg::*;

  twc_state_t state_reg;
  logic [7:0] client_control_a;
  logic ack_action;
  logic [7:0] client_addr_reg;
  logic [7:0] client_byte_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] bit_cnt_reg;
  logic byte_done_flag;
  logic address_stop_flag;
  logic address_or_stop_kind;
  logic host_ack_seen;
  logic arbitration_clash_flag;
  logic illegal_bus_flag;
  logic dir_reg;
  logic lost_reg;
  logic after_addr_reg;
  logic ack_wait_reg;
  logic gie_reg;

  logic scl_s;
  logic sda_s;
  logic start_p;
  logic stop_p;
  logic scl_rise;
  logic scl_fall;
  logic bus_err;

  logic enable;
  logic auto_step;
  logic cmd_wr;
  logic stat_wr;
  logic data_rd;
  logic data_wr;
  logic go_finish;
  logic go_response;
  logic ack_now;
  logic addr_match;
  logic end_byte;
  logic ack_clash;
  logic tx_clash;
  logic set_dif;
  logic set_address_stop_flag_addr;
  logic set_address_stop_flag_stop;
  logic set_address_stop_flag;
  logic set_arbitration_clash_flag;
  logic flag_clear;
  logic trig_rx;
  logic trig_tx;
  logic [7:0] status_word;

  twc_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  twc_cond u_cond (
    .clk(clk),
    .resetn(resetn),
    .scl(scl_s),
    .sda(sda_s),
    .start_p(start_p),
    .stop_p(stop_p),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .bus_err(bus_err)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign enable = client_control_a[CA_ENABLE];
  assign auto_step = client_control_a[CA_AUTO_STEP];
  assign cmd_wr = wr & hit(addr, OFS_CTRL_B);
  assign stat_wr = wr & hit(addr, OFS_STATUS);
  assign data_rd = rd & hit(addr, OFS_DATA);
  assign data_wr = wr & hit(addr, OFS_DATA);
  // Idle and reserved codes fall through both decodes untouched
  assign go_finish = cmd_wr & (wdata[1:0] == CMD_FINISH);
  assign go_response = cmd_wr & (wdata[1:0] == CMD_RESPONSE);
  // A value written together with the command wins over the stored one
  assign ack_now = cmd_wr ? wdata[CB_ACK_ACTION] : ack_action;

  assign addr_match = client_control_a[CA_MATCH_ALL] |
                      (shift_reg[7:1] == client_addr_reg[7:1]) |
                      (client_addr_reg[0] & (shift_reg[7:1] == 7'h00));
  assign end_byte = scl_fall & (bit_cnt_reg == BITS_PER_BYTE);

  // Auto-step lets a data access stand in for the response command
  assign trig_rx = go_response | (auto_step & data_rd);
  assign trig_tx = go_response | (auto_step & data_wr);

  always_comb begin
    ack_clash = (state_reg == ST_ACK_OUT) & scl_rise & ~sda_oe & ~sda_s;
    tx_clash = (state_reg == ST_TX_BYTE) & scl_rise & ~sda_oe & ~sda_s &
               ~lost_reg;
    set_arbitration_clash_flag = ack_clash | tx_clash;
    set_address_stop_flag_addr = (state_reg == ST_ADDRESS) & end_byte & addr_match;
    set_address_stop_flag_stop = stop_p & client_control_a[CA_STOP_IE] &
                    (state_reg != ST_IDLE);
    set_address_stop_flag = set_address_stop_flag_addr | set_address_stop_flag_stop | (ack_clash & after_addr_reg);
    set_dif = ((state_reg == ST_RX_BYTE) & end_byte) |
              ((state_reg == ST_HOST_ACK_BIT) & scl_fall) |
              ((state_reg == ST_ACK_OUT) & scl_fall & after_addr_reg &
               dir_reg & ~ack_wait_reg) |
              (ack_clash & ~after_addr_reg);
    flag_clear = data_rd | data_wr | go_finish | go_response;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      client_control_a <= REG_RESET;
      ack_action <= 1'b0;
      client_addr_reg <= REG_RESET;
      gie_reg <= 1'b0;
    end else begin
      gie_reg <= global_irq_enable;
      if (wr && hit(addr, OFS_CTRL_A)) begin
        client_control_a <= wdata & CTRL_A_MASK;
      end
      if (cmd_wr) begin
        ack_action <= wdata[CB_ACK_ACTION];
      end
      if (wr && hit(addr, OFS_ADDR)) begin
        client_addr_reg <= wdata;
      end
    end
  end

  // Shared flag and vector; the kind bit records the cause
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_done_flag <= 1'b0;
      address_stop_flag <= 1'b0;
      address_or_stop_kind <= 1'b0;
    end else begin
      if (set_dif) begin
        byte_done_flag <= 1'b1;
      end else if (flag_clear ||
                   (stat_wr && wdata[ST_BYTE_DONE])) begin
        byte_done_flag <= 1'b0;
      end
      if (set_address_stop_flag) begin
        address_stop_flag <= 1'b1;
      end else if (flag_clear ||
                   (stat_wr && wdata[ST_ADDR_STOP])) begin
        address_stop_flag <= 1'b0;
      end
      if (set_address_stop_flag_addr) begin
        address_or_stop_kind <= 1'b1;
      end else if (set_address_stop_flag_stop) begin
        address_or_stop_kind <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arbitration_clash_flag <= 1'b0;
      illegal_bus_flag <= 1'b0;
      host_ack_seen <= 1'b0;
    end else begin
      if (set_arbitration_clash_flag) begin
        arbitration_clash_flag <= 1'b1;
      end else if (start_p ||
                   (stat_wr && wdata[ST_CLASH])) begin
        arbitration_clash_flag <= 1'b0;
      end
      if (bus_err && enable) begin
        illegal_bus_flag <= 1'b1;
      end else if (stat_wr && wdata[ST_ILLEGAL]) begin
        illegal_bus_flag <= 1'b0;
      end
      if (state_reg == ST_HOST_ACK_BIT && scl_rise) begin
        host_ack_seen <= sda_s;
      end
    end
  end

  // Bus sequencer; the clock is held low only in the two hold states
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      shift_reg <= REG_RESET;
      tx_shift_reg <= REG_RESET;
      bit_cnt_reg <= 4'h0;
      dir_reg <= 1'b0;
      lost_reg <= 1'b0;
      after_addr_reg <= 1'b0;
      ack_wait_reg <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!enable || stop_p || bus_err) begin
      state_reg <= ST_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_p) begin
      state_reg <= ST_ADDRESS;
      bit_cnt_reg <= 4'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDRESS: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (end_byte) begin
            if (addr_match) begin
              dir_reg <= shift_reg[0];
              scl_oe <= 1'b1;
              state_reg <= ST_ADDR_HOLD;
            end else begin
              state_reg <= ST_WAIT_START;
            end
          end
        end
        ST_ADDR_HOLD: begin
          if (go_finish || trig_rx) begin
            sda_oe <= ~ack_now;
            ack_wait_reg <= go_finish | ack_now;
            after_addr_reg <= 1'b1;
            scl_oe <= 1'b0;
            state_reg <= ST_ACK_OUT;
          end
        end
        ST_ACK_OUT: begin
          if (ack_clash) begin
            sda_oe <= 1'b0;
            state_reg <= ST_WAIT_START;
          end else if (scl_fall) begin
            sda_oe <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (ack_wait_reg) begin
              state_reg <= ST_WAIT_START;
            end else if (after_addr_reg && dir_reg) begin
              scl_oe <= 1'b1;
              state_reg <= ST_DATA_HOLD;
            end else begin
              state_reg <= ST_RX_BYTE;
            end
          end
        end
        ST_RX_BYTE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (end_byte) begin
            scl_oe <= 1'b1;
            state_reg <= ST_DATA_HOLD;
          end
        end
        ST_TX_BYTE: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (tx_clash) begin
              lost_reg <= 1'b1;
            end
          end else if (scl_fall) begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              state_reg <= ST_HOST_ACK_BIT;
            end else begin
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              // After a lost bit the line is left alone to the end
              sda_oe <= ~lost_reg & ~tx_shift_reg[6];
            end
          end
        end
        ST_HOST_ACK_BIT: begin
          if (scl_fall) begin
            scl_oe <= 1'b1;
            state_reg <= ST_DATA_HOLD;
          end
        end
        ST_DATA_HOLD: begin
          after_addr_reg <= 1'b0;
          if (dir_reg) begin
            if (go_finish) begin
              scl_oe <= 1'b0;
              state_reg <= ST_WAIT_START;
            end else if (trig_tx) begin
              tx_shift_reg <= client_byte_reg;
              sda_oe <= ~client_byte_reg[7];
              lost_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              scl_oe <= 1'b0;
              state_reg <= ST_TX_BYTE;
            end
          end else if (go_finish || trig_rx) begin
            sda_oe <= ~ack_now;
            ack_wait_reg <= go_finish | ack_now;
            scl_oe <= 1'b0;
            state_reg <= ST_ACK_OUT;
          end
        end
        ST_IDLE, ST_WAIT_START: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Hardware loads received bytes only at the end of a byte, while the
  // clock is stretched, so software and shifter never collide
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      client_byte_reg <= REG_RESET;
    end else if (state_reg == ST_RX_BYTE && end_byte && !start_p &&
                 !stop_p) begin
      client_byte_reg <= shift_reg;
    end else if (data_wr) begin
      client_byte_reg <= wdata;
    end
  end

  always_comb begin
    status_word = REG_RESET;
    status_word[ST_BYTE_DONE] = byte_done_flag;
    status_word[ST_ADDR_STOP] = address_stop_flag;
    status_word[ST_STRETCH] = scl_oe;
    status_word[ST_HOST_ACK] = host_ack_seen;
    status_word[ST_CLASH] = arbitration_clash_flag;
    status_word[ST_ILLEGAL] = illegal_bus_flag;
    status_word[ST_DIR] = dir_reg;
    status_word[ST_KIND] = address_or_stop_kind;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= REG_RESET;
    end else if (rd) begin
      case (addr)
        OFS_CTRL_A: rdata <= client_control_a;
        // The command field never reads back
        OFS_CTRL_B: rdata <= {5'h00, ack_action, 2'h0};
        OFS_STATUS: rdata <= status_word;
        OFS_ADDR: rdata <= client_addr_reg;
        OFS_DATA: rdata <= client_byte_reg;
        default: rdata <= REG_RESET;
      endcase
    end else begin
      rdata <= REG_RESET;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_irq <= 1'b0;
      addr_stop_irq <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      byte_irq <= client_control_a[CA_BYTE_IE] & byte_done_flag &
                  gie_reg;
      addr_stop_irq <= client_control_a[CA_ADDR_STOP_IE] &
                       address_stop_flag & gie_reg;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end
endmodule : twc_client

// ---- twc_client_properties.sv ----
`timescale 1ns/1ps
module twc_client_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [twc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic global_irq_enable,
  input wire logic byte_irq,
  input wire logic addr_stop_irq
);
  import twc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  cmd_reads_zero_a: assert property (
    rd && addr == OFS_CTRL_B |=> rdata[1:0] == 2'h0)
    else $error("command field read back nonzero");
  stretch_read_a: assert property (
    rd && addr == OFS_STATUS |=> rdata[ST_STRETCH] == $past(scl_oe))
    else $error("clock hold bit differs from actual hold");
  hold_when_low_a: assert property (
    $rose(scl_oe) |-> !$past(scl_in))
    else $error("clock hold began while the clock was high");
  hold_release_a: assert property (
    $fell(scl_oe) |-> $past(wr) || $past(rd) || $past(wr, 2) || $past(rd, 2))
    else $error("clock hold dropped without a register access");
  sda_when_low_a: assert property (
    $changed(sda_oe) |-> !scl_in)
    else $error("data line changed while the clock was high");
  irq_gated_a: assert property (
    !global_irq_enable [*3] |-> !byte_irq && !addr_stop_irq)
    else $error("interrupt raised with global enable low");
  reserved_idle_a: assert property (
    wr && addr == OFS_CTRL_B && !wdata[1] && scl_oe |=> scl_oe [*2])
    else $error("idle or reserved command released the hold");
  cmd_release_a: assert property (
    wr && addr == OFS_CTRL_B && wdata[1] && scl_oe |-> ##[1:2] !scl_oe)
    else $error("command did not release the clock hold");
  flag_access_a: assert property (
    (byte_irq || addr_stop_irq) && (rd || wr) && addr == OFS_DATA && scl_oe
    |-> ##[1:3] !byte_irq && !addr_stop_irq)
    else $error("data access left an interrupt pending");
  bus_err_clear_a: assert property (
    (wr && addr == OFS_STATUS && wdata[ST_ILLEGAL]) ##[1:2]
    (rd && addr == OFS_STATUS) |=> !rdata[ST_ILLEGAL])
    else $error("bus error flag survived a write of one");
endmodule : twc_client_properties

bind twc_client twc_client_properties u_props (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .global_irq_enable(global_irq_enable), .byte_irq(byte_irq),
  .addr_stop_irq(addr_stop_irq)
);

// ---- twc_client_tb_top.sv ----
`timescale 1ns/1ps
module twc_client_tb_top;
  import twc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b1;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gie = 1'b1;
  logic [7:0] rdata, got, rx;
  logic scl_out, scl_oe, sda_out, sda_oe, byte_irq, addr_stop_irq;
  logic scl_low, sda_low, scl_w, sda_w, ack_bit;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [ADDR_W-1:0] reg_list [6] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_STATUS,
    OFS_ADDR, OFS_DATA, 4'h0};
  // Both wires have pull-ups: released reads high
  assign scl_w = ~(scl_low | scl_oe);
  assign sda_w = ~(sda_low | sda_oe);
  always #5 clk = ~clk;
  twc_client dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .global_irq_enable(gie), .byte_irq(byte_irq),
    .addr_stop_irq(addr_stop_irq)
  );
  twc_host_model host (
    .scl_wire(scl_w), .sda_wire(sda_w), .scl_low(scl_low), .sda_low(sda_low)
  );
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stand only in the cycle after the strobe
    #1 d = rdata;
  endtask : reg_rd
  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [7:0] m,
    input logic [7:0] exp, input string what);
    reg_rd(a, got);
    check(what, exp, got & m);
  endtask : chk_reg
  // Polls status; the caller judges the outcome
  task automatic wait_flag(input int b);
    got = 8'h00;
    for (int i = 0; i < 400 && got[b] !== 1'b1; i++) reg_rd(OFS_STATUS, got);
  endtask : wait_flag
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    // A real falling edge is needed to fire the asynchronous reset
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    foreach (reg_list[i]) chk_reg(reg_list[i], 8'hff, 8'h00, "reset value");
    reg_wr(OFS_CTRL_A, 8'hff);
    chk_reg(OFS_CTRL_A, 8'hff, CTRL_A_MASK, "ctrl_a");
    reg_wr(OFS_CTRL_B, 8'h07);
    chk_reg(OFS_CTRL_B, 8'hff, 8'h04, "ctrl_b");
    $display("test registers done");
    reg_wr(OFS_ADDR, 8'ha0);
    reg_wr(OFS_CTRL_A, 8'he3);
    reg_wr(OFS_CTRL_B, 8'h00);
    host.start_cond();
    host.send_byte(8'ha0);
    wait_flag(ST_ADDR_STOP);
    check("addr status", 8'h61, got & 8'he3);
    check("addr irq", 8'h01, {7'h00, addr_stop_irq});
    check("open drain", 8'h00, {6'h00, scl_out, sda_out});
    @(posedge clk);
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check("masked irq", 8'h00, {7'h00, addr_stop_irq});
    @(posedge clk);
    gie <= 1'b1;
    reg_wr(OFS_CTRL_B, 8'h01);
    reg_wr(OFS_CTRL_B, 8'h00);
    chk_reg(OFS_STATUS, 8'h60, 8'h60, "flag kept");
    reg_wr(OFS_CTRL_B, 8'h03);
    chk_reg(OFS_STATUS, 8'h40, 8'h00, "flag cleared");
    host.bit_cycle(1'b1, ack_bit);
    check("addr ack", 8'h00, {7'h00, ack_bit});
    host.send_byte(8'h5a);
    wait_flag(ST_BYTE_DONE);
    check("byte irq", 8'h01, {7'h00, byte_irq});
    chk_reg(OFS_DATA, 8'hff, 8'h5a, "rx byte");
    host.bit_cycle(1'b1, ack_bit);
    check("auto ack", 8'h00, {7'h00, ack_bit});
    host.send_byte(8'h3c);
    wait_flag(ST_BYTE_DONE);
    reg_wr(OFS_CTRL_B, 8'h06);
    host.bit_cycle(1'b1, ack_bit);
    check("final nack", 8'h01, {7'h00, ack_bit});
    chk_reg(OFS_STATUS, 8'hc0, 8'h00, "flags after cmd");
    host.stop_cond();
    wait_flag(ST_ADDR_STOP);
    check("stop status", 8'h40, got & 8'h41);
    reg_rd(OFS_DATA, got);
    $display("test host write done");
    reg_wr(OFS_CTRL_A, 8'hc1);
    host.start_cond();
    host.send_byte(8'h30);
    host.bit_cycle(1'b1, ack_bit);
    check("foreign nack", 8'h01, {7'h00, ack_bit});
    chk_reg(OFS_STATUS, 8'h40, 8'h00, "no match");
    host.stop_cond();
    chk_reg(OFS_STATUS, 8'h40, 8'h00, "stop unreported");
    reg_wr(OFS_CTRL_A, 8'hc5);
    host.start_cond();
    host.send_byte(8'h31);
    wait_flag(ST_ADDR_STOP);
    check("read dir", 8'h03, got & 8'h03);
    reg_wr(OFS_CTRL_B, 8'h03);
    host.bit_cycle(1'b1, ack_bit);
    check("read ack", 8'h00, {7'h00, ack_bit});
    wait_flag(ST_BYTE_DONE);
    check("byte flag", 8'h80, got & 8'h80);
    reg_wr(OFS_DATA, 8'hc3);
    reg_wr(OFS_CTRL_B, 8'h03);
    host.recv_byte(rx);
    check("tx byte", 8'hc3, rx);
    host.bit_cycle(1'b0, ack_bit);
    wait_flag(ST_BYTE_DONE);
    check("host ack", 8'h80, got & 8'h98);
    reg_wr(OFS_DATA, 8'hff);
    reg_wr(OFS_CTRL_B, 8'h03);
    // Host holds the data line low against the client's high bits
    host.send_byte(8'h00);
    host.bit_cycle(1'b1, ack_bit);
    wait_flag(ST_BYTE_DONE);
    check("clash nack", 8'h98, got & 8'h98);
    reg_wr(OFS_CTRL_B, 8'h02);
    chk_reg(OFS_STATUS, 8'h20, 8'h00, "hold released");
    host.stop_cond();
    $display("test host read done");
    host.glitch();
    wait_flag(ST_ILLEGAL);
    check("bus error", 8'h04, got & 8'h0c);
    reg_wr(OFS_STATUS, 8'h04);
    chk_reg(OFS_STATUS, 8'h04, 8'h00, "bus error clear");
    $display("test bus error done");
    test_done();
  end
endmodule : twc_client_tb_top

// ---- twc_cond.sv ----
`timescale 1ns/1ps
module twc_cond (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  output logic start_p,
  output logic stop_p,
  output logic scl_rise,
  output logic scl_fall,
  output logic bus_err
);
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic in_frame_reg;
  logic fall_seen_reg;
  logic start_now;
  logic stop_now;

  assign start_now = scl & scl_prev_reg & sda_prev_reg & ~sda;
  assign stop_now = scl & scl_prev_reg & ~sda_prev_reg & sda;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      start_p <= 1'b0;
      stop_p <= 1'b0;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
    end else begin
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
      start_p <= start_now;
      stop_p <= stop_now;
      scl_rise <= scl & ~scl_prev_reg;
      scl_fall <= ~scl & scl_prev_reg;
    end
  end

  // A stop with no clock pulse since the start is a protocol violation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_frame_reg <= 1'b0;
      fall_seen_reg <= 1'b0;
      bus_err <= 1'b0;
    end else begin
      bus_err <= stop_now & in_frame_reg & ~fall_seen_reg;
      if (start_now) begin
        in_frame_reg <= 1'b1;
        fall_seen_reg <= 1'b0;
      end else if (stop_now) begin
        in_frame_reg <= 1'b0;
      end else if (~scl & scl_prev_reg) begin
        fall_seen_reg <= 1'b1;
      end
    end
  end
endmodule : twc_cond

// ---- twc_host_model.sv ----
`timescale 1ns/1ps
module twc_host_model (
  input wire logic scl_wire,
  input wire logic sda_wire,
  output logic scl_low,
  output logic sda_low
);
  localparam real Q = 31.25;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // The high phase only counts once the client stops stretching
  task automatic bit_cycle(input logic val, output logic seen);
    sda_low = ~val;
    #Q;
    scl_low = 1'b0;
    wait (scl_wire);
    #Q;
    seen = sda_wire;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask : bit_cycle
  task automatic start_cond();
    sda_low = 1'b0;
    scl_low = 1'b0;
    wait (scl_wire);
    #Q;
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask : start_cond
  task automatic stop_cond();
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b0;
    wait (scl_wire);
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask : stop_cond
  // Start then stop with no clock pulse between: a protocol violation
  task automatic glitch();
    sda_low = 1'b1;
    #(2 * Q);
    sda_low = 1'b0;
    #(2 * Q);
  endtask : glitch
  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
  endtask : recv_byte
endmodule : twc_host_model

// ---- twc_pkg.sv ----
// Summary of operation
// - Address match and stop share one flag; a kind bit tells them apart.
// - Stop sets the address/stop flag only while stop reporting is enabled.
// - Match-all mode accepts every address, else own address, or address 0 when own address bit 0 is set.
// - Auto-step mode: code 3 write or data access clears flags and continues.
// - Enable bit switches the client function on.
// - Ack action sends ACK for 0, NACK for 1; never on data write.
// - Command field is a write strobe, reads zero; code 0 does nothing.
// - Code 2 runs ack action then waits for start; host read after byte flag only waits.
// - Code 3 after address flag runs ack action; after an ACK the byte flag follows.
// - Code 3 after byte flag sends a byte, or acks and receives next.
// - Ack value written with a command takes effect before that command.
// - Byte flag sets at byte end, also after a collided transfer.
// - Byte and address/stop flags clear on data access or code 2 or 3 command write.
// - Address/stop flag sets on own address or on reported stop.
// - Clock-hold bit reads one while the client stretches the clock.
// - Host-ack bit keeps the host's latest acknowledge, 1 for NACK.
// - Collision sets on lost high data bit or lost NACK after match.
// - Collision clears on write of one and on any start.
// - Illegal bus flag sets on protocol-violating stop; write one clears.
// - Kind bit reads 0 after a reported stop, 1 after an address.
// - Direction bit holds read/write bit of the last matching address received.
// - Each interrupt needs its enable, its flag and the global enable.
package twc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hb;
  localparam logic [ADDR_W-1:0] OFS_ADDR = 4'hc;
  localparam logic [ADDR_W-1:0] OFS_DATA = 4'hd;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CA_ENABLE = 0;
  localparam int CA_AUTO_STEP = 1;
  localparam int CA_MATCH_ALL = 2;
  localparam int CA_STOP_IE = 5;
  localparam int CA_ADDR_STOP_IE = 6;
  localparam int CA_BYTE_IE = 7;
  localparam int CB_ACK_ACTION = 2;
  localparam int ST_BYTE_DONE = 7;
  localparam int ST_ADDR_STOP = 6;
  localparam int ST_STRETCH = 5;
  localparam int ST_HOST_ACK = 4;
  localparam int ST_CLASH = 3;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_DIR = 1;
  localparam int ST_KIND = 0;
  localparam logic [7:0] CTRL_A_MASK = 8'he7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_RESERVED = 2'h1;
  localparam logic [1:0] CMD_FINISH = 2'h2;
  localparam logic [1:0] CMD_RESPONSE = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDRESS,
    ST_ADDR_HOLD,
    ST_ACK_OUT,
    ST_RX_BYTE,
    ST_TX_BYTE,
    ST_HOST_ACK_BIT,
    ST_DATA_HOLD,
    ST_WAIT_START
  } twc_state_t;
endpackage : twc_pkg

// ---- twc_sync.sv ----
`timescale 1ns/1ps
module twc_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Open-drain lines idle high, so the chain resets to ones
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '1;
      q <= '1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : twc_sync
